// ==== core/mfp_pkg.sv ====
// Shared constants and carrier types for the port group block
package mfp_pkg;

	// Bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets for the fourth port
	localparam logic [7:0] OFF_P4_LATCH = 8'h04;
	localparam logic [7:0] OFF_P4_TYPE = 8'h0a;
	localparam logic [7:0] OFF_P4_PIN = 8'h0e;

	// Register offsets for ports five to seven and key wakeup
	localparam logic [7:0] OFF_P5_LATCH = 8'h05;
	localparam logic [7:0] OFF_P5_PIN = 8'h0f;
	localparam logic [7:0] OFF_P6_DATA = 8'h06;
	localparam logic [7:0] OFF_P7_DATA = 8'h07;
	localparam logic [7:0] OFF_P6_DIR = 8'h10;
	localparam logic [7:0] OFF_P6_ISEL = 8'h11;
	localparam logic [7:0] OFF_P7_DIR = 8'h12;
	localparam logic [7:0] OFF_P7_ISEL = 8'h13;
	localparam logic [7:0] OFF_KEY_SEL = 8'h14;

	// Port widths and key wakeup field position
	localparam int P5_W = 5;
	localparam int KEY_W = 4;
	localparam int KEY_LSB = 4;

	// Reset values
	localparam logic [7:0] RST_P4_LATCH = 8'hff;
	localparam logic [7:0] RST_P4_TYPE = 8'h00;
	localparam logic [4:0] RST_P5_LATCH = 5'h1f;
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [7:0] RST_ISEL = 8'hff;
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [3:0] RST_KEY_SEL = 4'h0;
	localparam logic [7:0] RD_NONE = 8'h00;

	// Register port request from software
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} mfp_bus_t;

	// Drive pair of an eight-bit port
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} mfp_drive8_t;

endpackage : mfp_pkg

// ==== core/mfp_sync.sv ====
// Two-stage synchroniser for pin levels
module mfp_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_r <= '0;
			q_r <= '0;
		end
		else
		begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;
endmodule : mfp_sync

// ==== core/mfp_dir_read.sv ====
// Per-bit data read selection for a port with direction and input select
module mfp_dir_read #(
	parameter int W = 8
) (
	input wire logic [W-1:0] dir,
	input wire logic [W-1:0] isel,
	input wire logic [W-1:0] latch,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] value
);
	// Output bits show the latch, digital inputs the pin, analog inputs zero
	assign value = (dir & latch) | (~dir & isel & pin);
endmodule : mfp_dir_read

// ==== core/mfp_port_group.sv ====
// Port group four to seven: latches, controls, pin drive and read paths
// Function
// - Fourth-port type bit zero gives sink-only open drain, one push-pull.
// - Reset sets fourth-port latch to all ones, type control to zeros.
// - Fifth port has five bidirectional pins, bits four to zero.
// - Reset sets all fifth-port latch bits to one.
// - Fifth port reads latch and sampled pins at separate addresses.
// - Fifth-port read bits seven to five have no pins behind them.
// - Sixth port eight pins, direction one drives, input select one digital.
// - Reset clears sixth direction and latch, sets input select to ones.
// - Sixth data read gives zero, pin level or latch per control bits.
// - Digital input bits read pin level, so bit operations may rewrite latches.
// - Seventh port eight pins with direction and input select like sixth.
// - Reset clears seventh direction and latch, sets input select to ones.
// - Seventh data read gives zero, pin level or latch per control bits.
module mfp_port_group (
	input wire logic clk,
	input wire logic rst,
	input wire mfp_pkg::mfp_bus_t bus,
	output logic [7:0] rdata,
	input wire logic [7:0] p4_in,
	output logic [7:0] p4_out,
	output logic [7:0] p4_oe,
	input wire logic [4:0] p5_in,
	output logic [4:0] p5_out,
	output logic [4:0] p5_oe,
	input wire logic [7:0] p6_in,
	output logic [7:0] p6_out,
	output logic [7:0] p6_oe,
	input wire logic [7:0] p7_in,
	output logic [7:0] p7_out,
	output logic [7:0] p7_oe,
	output logic [7:0] port6_digital_enable,
	output logic [7:0] port7_digital_enable,
	output logic [3:0] key_wakeup_level
);

	// Software-visible registers
	logic [7:0] port4_output_latch_r;
	logic [7:0] port4_output_type_control_r;
	logic [4:0] port5_output_latch_r;
	logic [7:0] port6_data_r;
	logic [7:0] port6_direction_r;
	logic [7:0] port6_input_select_r;
	logic [7:0] port7_data_r;
	logic [7:0] port7_direction_r;
	logic [7:0] port7_input_select_r;
	logic [3:0] key_wakeup_input_select_r;

	// Registered pin drive and read data
	logic [7:0] p4_oe_r;
	logic [7:0] p4_oe_nxt;
	logic [4:0] p5_oe_r;
	logic [4:0] p5_oe_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [3:0] key_level_r;
	logic [3:0] key_level_nxt;

	// Synchronised pin levels
	logic [7:0] p4_sync;
	logic [4:0] p5_sync;
	logic [7:0] p6_sync;
	logic [7:0] p7_sync;

	// Data read values for the direction-controlled ports
	logic [7:0] p6_read;
	logic [7:0] p7_read;

	// Address matches, one per register
	logic hit_p4_latch;
	logic hit_p4_type;
	logic hit_p4_pin;
	logic hit_p5_latch;
	logic hit_p5_pin;
	logic hit_p6_data;
	logic hit_p6_dir;
	logic hit_p6_isel;
	logic hit_p7_data;
	logic hit_p7_dir;
	logic hit_p7_isel;
	logic hit_key_sel;

	// Address decode strobes
	logic wr_p4_latch;
	logic wr_p4_type;
	logic wr_p5_latch;
	logic wr_p6_data;
	logic wr_p6_dir;
	logic wr_p6_isel;
	logic wr_p7_data;
	logic wr_p7_dir;
	logic wr_p7_isel;
	logic wr_key_sel;
	logic [7:0] rd_mux;

	// Pins are asynchronous to the core, so every read path is synchronised
	// Two cycles of read latency are the price of a clean sample
	mfp_sync #(
		.W(8)
	) u_sync_p4 (
		.clk(clk),
		.rst(rst),
		.d(p4_in),
		.q(p4_sync)
	);

	mfp_sync #(
		.W(mfp_pkg::P5_W)
	) u_sync_p5 (
		.clk(clk),
		.rst(rst),
		.d(p5_in),
		.q(p5_sync)
	);

	mfp_sync #(
		.W(8)
	) u_sync_p6 (
		.clk(clk),
		.rst(rst),
		.d(p6_in),
		.q(p6_sync)
	);

	mfp_sync #(
		.W(8)
	) u_sync_p7 (
		.clk(clk),
		.rst(rst),
		.d(p7_in),
		.q(p7_sync)
	);

	// Sixth and seventh port data read selection
	mfp_dir_read #(
		.W(8)
	) u_read_p6 (
		.dir(port6_direction_r),
		.isel(port6_input_select_r),
		.latch(port6_data_r),
		.pin(p6_sync),
		.value(p6_read)
	);

	mfp_dir_read #(
		.W(8)
	) u_read_p7 (
		.dir(port7_direction_r),
		.isel(port7_input_select_r),
		.latch(port7_data_r),
		.pin(p7_sync),
		.value(p7_read)
	);

	// Address match; every register sits at exactly one offset
	assign hit_p4_latch = (bus.addr == mfp_pkg::OFF_P4_LATCH);
	assign hit_p4_type = (bus.addr == mfp_pkg::OFF_P4_TYPE);
	assign hit_p4_pin = (bus.addr == mfp_pkg::OFF_P4_PIN);
	assign hit_p5_latch = (bus.addr == mfp_pkg::OFF_P5_LATCH);
	assign hit_p5_pin = (bus.addr == mfp_pkg::OFF_P5_PIN);
	assign hit_p6_data = (bus.addr == mfp_pkg::OFF_P6_DATA);
	assign hit_p6_dir = (bus.addr == mfp_pkg::OFF_P6_DIR);
	assign hit_p6_isel = (bus.addr == mfp_pkg::OFF_P6_ISEL);
	assign hit_p7_data = (bus.addr == mfp_pkg::OFF_P7_DATA);
	assign hit_p7_dir = (bus.addr == mfp_pkg::OFF_P7_DIR);
	assign hit_p7_isel = (bus.addr == mfp_pkg::OFF_P7_ISEL);
	assign hit_key_sel = (bus.addr == mfp_pkg::OFF_KEY_SEL);

	// Write decode; the pin-state offsets are read-only and get no strobe
	assign wr_p4_latch = bus.wr && hit_p4_latch;
	assign wr_p4_type = bus.wr && hit_p4_type;
	assign wr_p5_latch = bus.wr && hit_p5_latch;
	assign wr_p6_data = bus.wr && hit_p6_data;
	assign wr_p6_dir = bus.wr && hit_p6_dir;
	assign wr_p6_isel = bus.wr && hit_p6_isel;
	assign wr_p7_data = bus.wr && hit_p7_data;
	assign wr_p7_dir = bus.wr && hit_p7_dir;
	assign wr_p7_isel = bus.wr && hit_p7_isel;
	assign wr_key_sel = bus.wr && hit_key_sel;

	// And-or of one-hot matches; unmapped offsets and pinless bits read zero
	assign rd_mux = ({8{hit_p4_latch}} & port4_output_latch_r)
		| ({8{hit_p4_type}} & port4_output_type_control_r)
		| ({8{hit_p4_pin}} & p4_sync)
		| ({8{hit_p5_latch}} & {3'h0, port5_output_latch_r})
		| ({8{hit_p5_pin}} & {3'h0, p5_sync})
		| ({8{hit_p6_data}} & p6_read)
		| ({8{hit_p6_dir}} & port6_direction_r)
		| ({8{hit_p6_isel}} & port6_input_select_r)
		| ({8{hit_p7_data}} & p7_read)
		| ({8{hit_p7_dir}} & port7_direction_r)
		| ({8{hit_p7_isel}} & port7_input_select_r)
		| ({8{hit_key_sel}} & {4'h0, key_wakeup_input_select_r});

	// Read data stand only in the cycle after the strobe
	// Idle cycles return zero, so a stale value never looks like a read
	assign rdata_nxt = bus.rd ? rd_mux : mfp_pkg::RD_NONE;

	// Open drain drives only a low latch; push-pull drives always
	// The enable lags a latch or type write by one cycle
	assign p4_oe_nxt = port4_output_type_control_r | ~port4_output_latch_r;

	// Fifth port sinks only, so a one latch releases the pin for bus use
	assign p5_oe_nxt = ~port5_output_latch_r;

	// Key wakeup looks at the upper four sixth-port pins where selected
	// Only the level leaves the block; wakeup sequencing lives elsewhere
	assign key_level_nxt = key_wakeup_input_select_r
		& p6_sync[mfp_pkg::KEY_LSB +: mfp_pkg::KEY_W];

	// Fourth port registers
	// Type bits reset to open drain, so a released pin never fights the board
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			port4_output_latch_r <= mfp_pkg::RST_P4_LATCH;
			port4_output_type_control_r <= mfp_pkg::RST_P4_TYPE;
		end
		else
		begin
			if (wr_p4_latch)
				port4_output_latch_r <= bus.wdata;
			if (wr_p4_type)
				port4_output_type_control_r <= bus.wdata;
		end
	end

	// Fifth port latch; upper data bits have no storage
	always_ff @(posedge clk)
	begin
		if (rst)
			port5_output_latch_r <= mfp_pkg::RST_P5_LATCH;
		else if (wr_p5_latch)
			port5_output_latch_r <= bus.wdata[mfp_pkg::P5_W-1:0];
	end

	// Sixth port registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			port6_data_r <= mfp_pkg::RST_DATA;
			port6_direction_r <= mfp_pkg::RST_DIR;
			port6_input_select_r <= mfp_pkg::RST_ISEL;
		end
		else
		begin
			if (wr_p6_data)
				port6_data_r <= bus.wdata;
			if (wr_p6_dir)
				port6_direction_r <= bus.wdata;
			if (wr_p6_isel)
				port6_input_select_r <= bus.wdata;
		end
	end

	// Seventh port registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			port7_data_r <= mfp_pkg::RST_DATA;
			port7_direction_r <= mfp_pkg::RST_DIR;
			port7_input_select_r <= mfp_pkg::RST_ISEL;
		end
		else
		begin
			if (wr_p7_data)
				port7_data_r <= bus.wdata;
			if (wr_p7_dir)
				port7_direction_r <= bus.wdata;
			if (wr_p7_isel)
				port7_input_select_r <= bus.wdata;
		end
	end

	// Key wakeup selection; clearing direction first is software's job
	always_ff @(posedge clk)
	begin
		if (rst)
			key_wakeup_input_select_r <= mfp_pkg::RST_KEY_SEL;
		else if (wr_key_sel)
			key_wakeup_input_select_r <= bus.wdata[mfp_pkg::KEY_W-1:0];
	end

	// Registered drive enables
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			p4_oe_r <= '0;
			p5_oe_r <= '0;
		end
		else
		begin
			p4_oe_r <= p4_oe_nxt;
			p5_oe_r <= p5_oe_nxt;
		end
	end

	// Registered read data and wakeup levels
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdata_r <= mfp_pkg::RD_NONE;
			key_level_r <= '0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			key_level_r <= key_level_nxt;
		end
	end

	// Pin drive: the value is always the latch, the enable decides
	assign p4_out = port4_output_latch_r;
	assign p4_oe = p4_oe_r;
	assign p5_out = port5_output_latch_r;
	assign p5_oe = p5_oe_r;
	assign p6_out = port6_data_r;
	assign p6_oe = port6_direction_r;
	assign p7_out = port7_data_r;
	assign p7_oe = port7_direction_r;

	// Digital input gates for the analog-capable ports
	assign port6_digital_enable = port6_input_select_r;
	assign port7_digital_enable = port7_input_select_r;

	// Remaining outputs come straight from their flip-flops
	assign key_wakeup_level = key_level_r;
	assign rdata = rdata_r;

endmodule : mfp_port_group

// ==== sim/mfp_pin_model.sv ====
// Board-side model of one port's pins
module mfp_pin_model #(
	parameter int W = 8
) (
	input wire logic [W-1:0] out,
	input wire logic [W-1:0] oe,
	input wire logic [W-1:0] ext,
	output logic [W-1:0] lvl
);
	timeunit 1ns;
	timeprecision 100ps;
	// A driven bit follows the block; a released bit shows the outside source
	assign lvl = (oe & out) | (~oe & ext);
endmodule : mfp_pin_model

// ==== sim/mfp_port_checker.sv ====
// Port-level assertions for the port group block
module mfp_port_checker (
	input wire logic clk,
	input wire logic rst,
	input wire mfp_pkg::mfp_bus_t bus,
	input wire logic [7:0] rdata,
	input wire logic [7:0] p4_out,
	input wire logic [7:0] p4_oe,
	input wire logic [4:0] p5_out,
	input wire logic [4:0] p5_oe,
	input wire logic [7:0] p6_out,
	input wire logic [7:0] p6_oe,
	input wire logic [7:0] p7_out,
	input wire logic [7:0] p7_oe,
	input wire logic [7:0] port6_digital_enable,
	input wire logic [7:0] port7_digital_enable
);
	timeunit 1ns;
	timeprecision 100ps;
	// One clock domain, so clocking and disable are set once
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Reset values seen at the first edge after release
	a_p4_reset: assert property (
		$fell(rst) |-> p4_out == 8'hff && p4_oe == 8'h00)
		else $error("port4 reset state wrong");
	a_p5_reset: assert property (
		$fell(rst) |-> p5_out == 5'h1f)
		else $error("port5 reset latch wrong");
	a_p67_reset: assert property (
		$fell(rst) |-> {p6_oe, p6_out, p7_oe, p7_out} == 32'h0 &&
		port6_digital_enable == 8'hff && port7_digital_enable == 8'hff)
		else $error("port6 or port7 reset state wrong");
	// Drivers: a low port4 or port5 latch bit must always sink, one cycle late; port6 oe follows a direction write
	a_p4_sink_drive: assert property (
		!$past(rst) |-> (p4_oe | $past(p4_out)) == 8'hff)
		else $error("port4 low bit not driven");
	a_p5_sink_only: assert property (
		!$past(rst) |-> p5_oe == ~$past(p5_out))
		else $error("port5 drive enable wrong");
	a_p6_dir_drive: assert property (
		bus.wr && bus.addr == mfp_pkg::OFF_P6_DIR |=> p6_oe == $past(bus.wdata))
		else $error("port6 direction not applied");
	// Read paths
	a_p5_latch_read: assert property (
		$past(bus.rd) && $past(bus.addr) == mfp_pkg::OFF_P5_LATCH |->
		rdata == {3'h0, $past(p5_out)})
		else $error("port5 latch read wrong");
	a_p5_upper_bits: assert property (
		$past(bus.rd) && $past(bus.addr) == mfp_pkg::OFF_P5_PIN |-> rdata[7:5] == 3'h0)
		else $error("port5 pin read upper bits set");
	a_p6_read_sel: assert property (
		$past(bus.rd) && $past(bus.addr) == mfp_pkg::OFF_P6_DATA |->
		((rdata ^ $past(p6_out)) & $past(p6_oe)) == 8'h00 &&
		(rdata & ~$past(p6_oe) & ~$past(port6_digital_enable)) == 8'h00)
		else $error("port6 data read selection wrong");
	a_p7_read_sel: assert property (
		$past(bus.rd) && $past(bus.addr) == mfp_pkg::OFF_P7_DATA |->
		((rdata ^ $past(p7_out)) & $past(p7_oe)) == 8'h00 &&
		(rdata & ~$past(p7_oe) & ~$past(port7_digital_enable)) == 8'h00)
		else $error("port7 data read selection wrong");
endmodule : mfp_port_checker

bind mfp_port_group mfp_port_checker chk (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
	.p4_out(p4_out), .p4_oe(p4_oe), .p5_out(p5_out), .p5_oe(p5_oe),
	.p6_out(p6_out), .p6_oe(p6_oe), .p7_out(p7_out), .p7_oe(p7_oe),
	.port6_digital_enable(port6_digital_enable), .port7_digital_enable(port7_digital_enable));

// ==== sim/testbench.sv ====
// Self-checking bench for the port group block
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
$display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	mfp_pkg::mfp_bus_t bus = '0;
	logic [7:0] rdata, r, p4_out, p4_oe, p6_out, p6_oe, p7_out, p7_oe, de6, de7;
	logic [7:0] l4, l6, l7, e4 = 8'h97, e6 = 8'h5a, e7 = 8'hc3;
	logic [4:0] p5_out, p5_oe, l5, e5 = 5'h1f;
	logic [3:0] key;
	int err_count = 0;
	int checked = 0;

	// 40 MHz clock
	always #12.5 clk = ~clk;

	mfp_port_group dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
		.p4_in(l4), .p4_out(p4_out), .p4_oe(p4_oe), .p5_in(l5), .p5_out(p5_out), .p5_oe(p5_oe),
		.p6_in(l6), .p6_out(p6_out), .p6_oe(p6_oe), .p7_in(l7), .p7_out(p7_out), .p7_oe(p7_oe),
		.port6_digital_enable(de6), .port7_digital_enable(de7), .key_wakeup_level(key));
	mfp_pin_model pm4 (.out(p4_out), .oe(p4_oe), .ext(e4), .lvl(l4));
	mfp_pin_model #(.W(5)) pm5 (.out(p5_out), .oe(p5_oe), .ext(e5), .lvl(l5));
	mfp_pin_model pm6 (.out(p6_out), .oe(p6_oe), .ext(e6), .lvl(l6));
	mfp_pin_model pm7 (.out(p7_out), .oe(p7_oe), .ext(e7), .lvl(l7));

	// One register access; read data is taken in the cycle after the strobe
	task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
		bus <= '{a, d, w, ~w};
		@(posedge clk);
		bus <= '{a, d, 1'b0, 1'b0};
		#1 r = rdata;
		@(posedge clk);
	endtask : io

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		io(1'b0, a, 8'h00);
		`CHK(r, e)
	endtask : rc

	// Mixed direction: high nibble drives latch, low nibble reads pins where digital
	task automatic mix(input logic [7:0] od, input logic [7:0] oi, input logic [7:0] oa);
		io(1'b1, oa, 8'ha5);
		io(1'b1, od, 8'hf0);
		io(1'b1, oi, 8'h0c);
		repeat (3) @(posedge clk);
		rc(oa, 8'hac);
	endtask : mix

	task automatic test_done;
		$display("checks %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	// Hang guard
	initial
	begin
		#100000;
		err_count++;
		test_done();
	end

	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rc(mfp_pkg::OFF_P4_LATCH, 8'hff);
		rc(mfp_pkg::OFF_P4_TYPE, 8'h00);
		rc(mfp_pkg::OFF_P4_PIN, 8'h97);
		rc(mfp_pkg::OFF_P5_LATCH, 8'h1f);
		rc(mfp_pkg::OFF_P6_DIR, 8'h00);
		rc(mfp_pkg::OFF_P6_ISEL, 8'hff);
		rc(mfp_pkg::OFF_P6_DATA, 8'h5a);
		rc(mfp_pkg::OFF_P7_DIR, 8'h00);
		rc(mfp_pkg::OFF_P7_ISEL, 8'hff);
		rc(mfp_pkg::OFF_P7_DATA, 8'hc3);
		// Unmapped and read-only places keep nothing
		io(1'b1, 8'h20, 8'h77);
		rc(8'h20, 8'h00);
		io(1'b1, mfp_pkg::OFF_P4_PIN, 8'h00);
		// Fourth port: open drain sinks bit 0, then push-pull drives all
		io(1'b1, mfp_pkg::OFF_P4_LATCH, 8'hfe);
		repeat (3) @(posedge clk);
		`CHK(p4_oe, 8'h01)
		rc(mfp_pkg::OFF_P4_PIN, 8'h96);
		io(1'b1, mfp_pkg::OFF_P4_TYPE, 8'hff);
		repeat (3) @(posedge clk);
		`CHK(p4_oe, 8'hff)
		rc(mfp_pkg::OFF_P4_PIN, 8'hfe);
		io(1'b1, mfp_pkg::OFF_P4_LATCH, 8'hff);
		io(1'b1, mfp_pkg::OFF_P4_TYPE, 8'h00);
		@(posedge clk);
		`CHK(p4_oe, 8'h00)
		// Fifth port: latch and pin paths differ when a pin is pulled low outside
		e5 <= 5'h12;
		io(1'b1, mfp_pkg::OFF_P5_LATCH, 8'h0a);
		@(posedge clk); // Enable lags the latch write by one cycle
		`CHK(p5_oe, 5'h15)
		rc(mfp_pkg::OFF_P5_LATCH, 8'h0a);
		repeat (2) @(posedge clk);
		rc(mfp_pkg::OFF_P5_PIN, 8'h02);
		// Sixth and seventh ports with mixed direction and analog bits
		e6 <= 8'h3c; // Held still while analog bits are in use
		e7 <= 8'h3c;
		mix(mfp_pkg::OFF_P6_DIR, mfp_pkg::OFF_P6_ISEL, mfp_pkg::OFF_P6_DATA);
		`CHK({p6_oe, p6_out, de6}, 24'hf0a50c)
		mix(mfp_pkg::OFF_P7_DIR, mfp_pkg::OFF_P7_ISEL, mfp_pkg::OFF_P7_DATA);
		`CHK({p7_oe, p7_out, de7}, 24'hf0a50c)
		// Read-modify-write copies pin states into the input bits' latch
		rc(mfp_pkg::OFF_P6_DATA, 8'hac);
		io(1'b1, mfp_pkg::OFF_P6_DATA, r);
		io(1'b1, mfp_pkg::OFF_P6_DIR, 8'hfc); // Analog bits stay inputs
		rc(mfp_pkg::OFF_P6_DATA, 8'hac);
		// Key wakeup on the sixth port's upper pins
		io(1'b1, mfp_pkg::OFF_P6_DIR, 8'h00);
		io(1'b1, mfp_pkg::OFF_KEY_SEL, 8'h05);
		repeat (4) @(posedge clk);
		`CHK(key, 4'h1)
		test_done();
	end
endmodule : testbench
